// file: hw/sciil_core.sv
`timescale 1ns/10ps
module sciil_core
   import sciil_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic connected,
   input wire logic cmd_valid,
   input wire logic [4:0] cmd_code,
   input wire logic [CNT_W-1:0] cnt_load,
   input wire logic cnt_load_en,
   input wire logic [7:0] ctrl,
   input wire logic cause_rd,
   input wire sciil_bus_t bus_in,
   output logic irq,
   output logic [7:0] irq_cause_reg,
   output logic [7:0] bus_phase_status_reg,
   output logic atn_out,
   output logic ack_out,
   output logic xfer_busy,
   output logic [CNT_W-1:0] byte_count
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [5:0] bus_sync;
   sciil_bus_t bus;
   sciil_sync #(.W(6)) u_sync (
      .clock(clock),
      .arst_n(arst_n),
      .d(bus_in),
      .q(bus_sync)
   );
   assign bus = sciil_bus_t'(bus_sync);
   wire logic [2:0] phase_now = {bus.msg, bus.cd, bus.io};
   // ------------------------------------------------------------
   // Phase change qualification
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      Q_IDLE = 3'b001,
      Q_PHASE = 3'b010,
      Q_BSY = 3'b100
   } sciil_qual_t;
   sciil_qual_t q_r, q_nxt;
   logic [3:0] qcnt_r, qcnt_nxt;
   logic [2:0] ref_phase_r;
   logic phase_ok_r;
   wire logic gate_on = ctrl[CTRL_PHASE_GATE_BIT];
   wire logic differs = phase_now != ref_phase_r;
   wire logic seen = differs && (!gate_on || bus.req);
   wire logic qual_done = qcnt_r == QUAL_CYCLES - 4'h1;
   logic phase_evt;
   always_comb begin
      q_nxt = q_r;
      qcnt_nxt = qcnt_r;
      phase_evt = 1'b0;
      case (q_r)
         Q_IDLE: begin
            qcnt_nxt = 4'h0;
            if (connected && seen) begin
               q_nxt = Q_PHASE;
            end
         end
         Q_PHASE: begin
            qcnt_nxt = qcnt_r + 4'h1;
            if (!differs) begin
               q_nxt = Q_IDLE;
            end else if (qual_done) begin
               q_nxt = Q_BSY;
               qcnt_nxt = 4'h0;
            end
         end
         Q_BSY: begin
            qcnt_nxt = qcnt_r + 4'h1;
            if (!bus.bsy) begin
               q_nxt = Q_IDLE;
            end else if (qual_done) begin
               q_nxt = Q_IDLE;
               phase_evt = 1'b1;
            end
         end
         default: q_nxt = Q_IDLE;
      endcase
   end
   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   wire logic is_xfer = cmd_code == CMD_PHASE_XFER || cmd_code == CMD_PAD_XFER;
   wire logic is_imm = cmd_code == CMD_DEV_RESET || cmd_code == CMD_DISCONNECT
      || cmd_code == CMD_RAISE_ATN || cmd_code == CMD_RELEASE_ACK;
   wire logic cmd_ok = cmd_valid && connected && (is_xfer || is_imm);
   wire logic cmd_bad = cmd_valid && connected && !(is_xfer || is_imm);
   wire logic do_reset = cmd_valid && cmd_code == CMD_DEV_RESET;
   wire logic start_xfer = cmd_ok && is_xfer;
   // ------------------------------------------------------------
   // Transfer engine state
   // ------------------------------------------------------------
   logic busy_r;
   logic [2:0] xfer_phase_r;
   logic par_atn_r;
   logic user_atn_r;
   logic ack_hold_r;
   logic req_d_r;
   logic cntz_r;
   logic bsy_d_r;
   wire logic req_rise = bus.req && !req_d_r;
   wire logic cnt_zero = byte_count == '0;
   wire logic req_unserv = connected && req_rise && !ack_hold_r
      && (!busy_r || cnt_zero);
   wire logic beat = busy_r && req_rise && !cnt_zero && !ack_hold_r;
   wire logic last_beat = beat && byte_count == CNT_W'(1);
   wire logic msgin_done = last_beat && xfer_phase_r == PHASE_MSG_IN;
   wire logic msgout_done = last_beat && xfer_phase_r == PHASE_MSG_OUT;
   wire logic disc_evt = connected && bsy_d_r && !bus.bsy;
   wire logic par_hit = beat && bus.par_err && xfer_phase_r != PHASE_MSG_OUT;
   // Deferred parity shows once count empties or phase moves
   wire logic par_flush = par_atn_r && busy_r && last_beat && !msgout_done;
   // ------------------------------------------------------------
   // Event priority and cause code
   // ------------------------------------------------------------
   logic [7:0] cause_nxt;
   always_comb begin
      cause_nxt = CAUSE_NONE;
      if (disc_evt) begin
         cause_nxt = CAUSE_DISC;
      end else if (cmd_bad) begin
         cause_nxt = CAUSE_BADCMD;
      end else if (req_unserv || phase_evt || par_flush) begin
         cause_nxt = CAUSE_SVC;
      end else if (msgin_done) begin
         cause_nxt = CAUSE_DONE;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q_r <= Q_IDLE;
         qcnt_r <= 4'h0;
         ref_phase_r <= 3'h0;
         busy_r <= 1'b0;
         xfer_phase_r <= 3'h0;
         par_atn_r <= 1'b0;
         user_atn_r <= 1'b0;
         ack_hold_r <= 1'b0;
         req_d_r <= 1'b0;
         bsy_d_r <= 1'b0;
         cntz_r <= 1'b0;
         byte_count <= '0;
         irq <= 1'b0;
         irq_cause_reg <= CAUSE_NONE;
      end else if (do_reset) begin
         q_r <= Q_IDLE;
         qcnt_r <= 4'h0;
         busy_r <= 1'b0;
         par_atn_r <= 1'b0;
         user_atn_r <= 1'b0;
         ack_hold_r <= 1'b0;
         cntz_r <= 1'b0;
         byte_count <= '0;
         irq <= 1'b0;
         irq_cause_reg <= CAUSE_NONE;
      end else begin
         q_r <= q_nxt;
         qcnt_r <= qcnt_nxt;
         req_d_r <= bus.req;
         bsy_d_r <= bus.bsy;
         // Gated change stays pending until REQ, so it is not lost
         if (phase_evt) begin
            ref_phase_r <= phase_now;
         end
         if (cnt_load_en) begin
            byte_count <= cnt_load;
         end else if (beat) begin
            byte_count <= byte_count - CNT_W'(1);
         end
         if (start_xfer) begin
            busy_r <= 1'b1;
            xfer_phase_r <= phase_now;
         // Outside the message phases busy holds at zero count so a further REQ reads as overflow
         end else if (msgin_done || msgout_done || req_unserv || phase_evt || disc_evt) begin
            busy_r <= 1'b0;
         end
         if (req_unserv && busy_r && cnt_zero) begin
            cntz_r <= 1'b1;
         end else if (start_xfer) begin
            cntz_r <= 1'b0;
         end
         if (par_hit) begin
            par_atn_r <= 1'b1;
         end else if (msgout_done) begin
            par_atn_r <= 1'b0;
         end
         if (cmd_ok && cmd_code == CMD_RAISE_ATN) begin
            user_atn_r <= 1'b1;
         end else if (msgout_done || disc_evt) begin
            user_atn_r <= 1'b0;
         end
         if (msgin_done) begin
            ack_hold_r <= 1'b1;
         end else if (cmd_ok && cmd_code == CMD_RELEASE_ACK || disc_evt) begin
            ack_hold_r <= 1'b0;
         end
         // New event wins over the clearing read
         if (cause_nxt != CAUSE_NONE) begin
            irq <= 1'b1;
            irq_cause_reg <= cause_nxt;
         end else if (cause_rd) begin
            irq <= 1'b0;
            irq_cause_reg <= CAUSE_NONE;
         end
      end
   end
   // ------------------------------------------------------------
   // Status and bus outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_phase_status_reg <= 8'h00;
         atn_out <= 1'b0;
         ack_out <= 1'b0;
         xfer_busy <= 1'b0;
      end else begin
         bus_phase_status_reg <= {1'b0, par_atn_r, 1'b0, cntz_r, 1'b0, phase_now};
         atn_out <= par_atn_r || user_atn_r;
         ack_out <= ack_hold_r || beat;
         xfer_busy <= busy_r;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_badcmd;
      @(posedge clock) disable iff (!arst_n)
      cmd_bad && !disc_evt && !do_reset |=> irq && irq_cause_reg == CAUSE_BADCMD;
   endproperty
   a_badcmd: assert property (p_badcmd) else $error("bad command not flagged");
   property p_disc;
      @(posedge clock) disable iff (!arst_n)
      disc_evt && !do_reset |=> irq_cause_reg == CAUSE_DISC;
   endproperty
   a_disc: assert property (p_disc) else $error("disconnect cause wrong");
   property p_par_atn;
      @(posedge clock) disable iff (!arst_n)
      par_hit && !do_reset |=> ##1 atn_out;
   endproperty
   a_par_atn: assert property (p_par_atn) else $error("parity ATN missing");
   property p_atn_hold;
      @(posedge clock) disable iff (!arst_n)
      par_atn_r && !msgout_done && !disc_evt && !do_reset |=> par_atn_r;
   endproperty
   a_atn_hold: assert property (p_atn_hold) else $error("parity ATN dropped early");
   property p_msgin;
      @(posedge clock) disable iff (!arst_n)
      msgin_done && !disc_evt && !cmd_bad && !do_reset && !par_flush
      |=> irq_cause_reg == CAUSE_DONE ##1 ack_out;
   endproperty
   a_msgin: assert property (p_msgin) else $error("message in completion wrong");
   sequence s_phase_held;
      q_r == Q_PHASE [*8];
   endsequence
   property p_qual;
      @(posedge clock) disable iff (!arst_n)
      phase_evt |-> $past(q_r, 12) == Q_PHASE && bus.bsy;
   endproperty
   a_qual: assert property (p_qual) else $error("phase event without qualification");
   property p_gate;
      @(posedge clock) disable iff (!arst_n)
      q_r == Q_IDLE && q_nxt == Q_PHASE |-> !gate_on || bus.req;
   endproperty
   a_gate: assert property (p_gate) else $error("gated phase change without REQ");
   property p_hold;
      @(posedge clock) disable iff (!arst_n)
      irq && !cause_rd && !do_reset |=> irq;
   endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped without read");
   property p_cntz;
      @(posedge clock) disable iff (!arst_n)
      req_unserv && busy_r && cnt_zero && !do_reset |=> ##1 bus_phase_status_reg[STAT_CNTZ_BIT];
   endproperty
   a_cntz: assert property (p_cntz) else $error("count-zero flag not set");
endmodule : sciil_core

// file: hw/sciil_pkg.sv
package sciil_pkg;
   // ------------------------------------------------------------
   // Cause codes
   // ------------------------------------------------------------
   localparam logic [7:0] CAUSE_NONE = 8'h00;
   localparam logic [7:0] CAUSE_DONE = 8'h01;
   localparam logic [7:0] CAUSE_SVC = 8'h02;
   localparam logic [7:0] CAUSE_DISC = 8'h04;
   localparam logic [7:0] CAUSE_BADCMD = 8'h40;
   // ------------------------------------------------------------
   // Command codes (5-bit command field)
   // ------------------------------------------------------------
   localparam logic [4:0] CMD_DEV_RESET = 5'h00;
   localparam logic [4:0] CMD_DISCONNECT = 5'h01;
   localparam logic [4:0] CMD_RAISE_ATN = 5'h03;
   localparam logic [4:0] CMD_RELEASE_ACK = 5'h04;
   localparam logic [4:0] CMD_PHASE_XFER = 5'h14;
   localparam logic [4:0] CMD_PAD_XFER = 5'h15;
   // ------------------------------------------------------------
   // Status and control bit positions and phase codes
   // ------------------------------------------------------------
   localparam int STAT_PARITY_BIT = 6;
   localparam int STAT_CNTZ_BIT = 4;
   localparam int CTRL_PHASE_GATE_BIT = 3;
   localparam logic [2:0] PHASE_MSG_OUT = 3'h6;
   localparam logic [2:0] PHASE_MSG_IN = 3'h7;
   // ------------------------------------------------------------
   // Qualification timing and count width
   // ------------------------------------------------------------
   localparam int QUAL_PERIODS = 12;
   localparam logic [3:0] QUAL_CYCLES = 4'(QUAL_PERIODS);
   localparam int CNT_W = 24;
   // Bus lines: msg, cd, io order matches phase code {msg,cd,io}
   typedef struct packed {
      logic bsy;
      logic req;
      logic msg;
      logic cd;
      logic io;
      logic par_err;
   } sciil_bus_t;
endpackage : sciil_pkg

// file: hw/sciil_sync.sv
`timescale 1ns/10ps
module sciil_sync
   import sciil_pkg::*;
#(
   parameter int W = 6
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Accept a change only once stages two and three agree
   // Per-bit stages keep each flop owned by one process
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic q_r;
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               q_r <= 1'b0;
            end else begin
               s1_r <= d[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  q_r <= s3_r;
               end
            end
         end
         assign q[i] = q_r;
      end
   endgenerate
endmodule : sciil_sync

// file: bench/sciil_target.sv
`timescale 1ns/10ps
module sciil_target
   import sciil_pkg::*;
(
   input wire logic clock,
   input wire logic ack_out,
   output sciil_bus_t bus_in
);
   initial begin
      bus_in = '0;
      bus_in.bsy = 1'b1;
   end
   task automatic set_phase(input logic [2:0] ph);
      @(posedge clock);
      {bus_in.msg, bus_in.cd, bus_in.io} <= ph;
   endtask : set_phase
   // ------------------------------------------------------------
   // One byte per REQ; a real target waits for ACK, bounded here
   // ------------------------------------------------------------
   task automatic beat(input logic perr);
      int n;
      @(posedge clock);
      bus_in.req <= 1'b1;
      bus_in.par_err <= perr;
      n = 0;
      while (ack_out !== 1'b1 && n < 12) begin
         @(posedge clock);
         n++;
      end
      bus_in.req <= 1'b0;
      bus_in.par_err <= 1'b0;
      repeat (6) @(posedge clock);
   endtask : beat
   task automatic drop_bsy();
      @(posedge clock);
      bus_in.bsy <= 1'b0;
   endtask : drop_bsy
endmodule : sciil_target

// file: bench/sciil_core_tb.sv
`timescale 1ns/10ps
module sciil_core_tb
   import sciil_pkg::*;
;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic connected = 1'b1;
   logic cmd_valid = 1'b0;
   logic [4:0] cmd_code = 5'h00;
   logic [CNT_W-1:0] cnt_load = '0;
   logic cnt_load_en = 1'b0;
   logic [7:0] ctrl = 8'h00;
   logic cause_rd = 1'b0;
   sciil_bus_t bus_in;
   logic irq, atn_out, ack_out, xfer_busy;
   logic [7:0] irq_cause_reg, bus_phase_status_reg;
   logic [CNT_W-1:0] byte_count;
   int n_mismatch = 0;
   int check_count = 0;

   always #10 clock = ~clock;

   sciil_core dut (.clock(clock), .arst_n(arst_n), .connected(connected),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cnt_load(cnt_load),
      .cnt_load_en(cnt_load_en), .ctrl(ctrl), .cause_rd(cause_rd), .bus_in(bus_in),
      .irq(irq), .irq_cause_reg(irq_cause_reg),
      .bus_phase_status_reg(bus_phase_status_reg), .atn_out(atn_out),
      .ack_out(ack_out), .xfer_busy(xfer_busy), .byte_count(byte_count));

   sciil_target tgt (.clock(clock), .ack_out(ack_out), .bus_in(bus_in));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic host_cmd(input logic [4:0] code);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      @(posedge clock);
      cmd_valid <= 1'b0;
   endtask : host_cmd

   task automatic load_count(input logic [CNT_W-1:0] v);
      @(posedge clock);
      cnt_load <= v;
      cnt_load_en <= 1'b1;
      @(posedge clock);
      cnt_load_en <= 1'b0;
   endtask : load_count

   // Bounded wait; a lost interrupt ends the run
   task automatic wait_irq(input int limit);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < limit) begin
         @(posedge clock);
         n++;
      end
      if (irq !== 1'b1) begin
         n_mismatch++;
         $display("unexpected irq timeout expected 1 seen %b", irq);
         give_verdict();
      end
   endtask : wait_irq

   task automatic read_cause(input logic [7:0] exp);
      check("cause", irq_cause_reg, exp);
      @(posedge clock);
      cause_rd <= 1'b1;
      @(posedge clock);
      cause_rd <= 1'b0;
      repeat (2) @(posedge clock);
      check("irq after read", irq, 1'b0);
   endtask : read_cause

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_bad_cmd();
      @(posedge clock);
      connected <= 1'b0;
      host_cmd(5'h08);
      repeat (4) @(posedge clock);
      check("irq when idle", irq, 1'b0);
      connected <= 1'b1;
      host_cmd(5'h08);
      wait_irq(10);
      repeat (3) @(posedge clock);
      check("irq held", irq, 1'b1);
      read_cause(CAUSE_BADCMD);
      host_cmd(CMD_RAISE_ATN);
      repeat (4) @(posedge clock);
      check("irq on valid cmd", irq, 1'b0);
      check("atn by command", atn_out, 1'b1);
      host_cmd(CMD_DEV_RESET);
      repeat (3) @(posedge clock);
      check("atn after reset", atn_out, 1'b0);
      $display("test bad_cmd done");
   endtask : t_bad_cmd

   task automatic t_phase_change();
      tgt.set_phase(3'h2);
      repeat (5) @(posedge clock);
      tgt.set_phase(3'h0);
      repeat (50) @(posedge clock);
      check("irq glitch", irq, 1'b0);
      tgt.set_phase(PHASE_MSG_IN);
      repeat (20) @(posedge clock);
      check("irq early", irq, 1'b0);
      wait_irq(40);
      check("phase lines", bus_phase_status_reg[2:0], PHASE_MSG_IN);
      read_cause(CAUSE_SVC);
      $display("test phase_change done");
   endtask : t_phase_change

   task automatic t_msg_in();
      load_count(24'h000001);
      host_cmd(CMD_PHASE_XFER);
      repeat (2) @(posedge clock);
      check("busy", xfer_busy, 1'b1);
      tgt.beat(1'b0);
      wait_irq(20);
      check("count", byte_count, 24'h000000);
      check("ack held", ack_out, 1'b1);
      read_cause(CAUSE_DONE);
      check("busy after msg in", xfer_busy, 1'b0);
      check("ack still held", ack_out, 1'b1);
      host_cmd(CMD_RELEASE_ACK);
      repeat (4) @(posedge clock);
      check("ack released", ack_out, 1'b0);
      $display("test msg_in done");
   endtask : t_msg_in

   task automatic t_gate();
      @(posedge clock);
      ctrl[CTRL_PHASE_GATE_BIT] <= 1'b1;
      tgt.set_phase(3'h2);
      repeat (60) @(posedge clock);
      check("irq gated", irq, 1'b0);
      ctrl[CTRL_PHASE_GATE_BIT] <= 1'b0;
      wait_irq(40);
      check("gated phase lines", bus_phase_status_reg[2:0], 3'h2);
      read_cause(CAUSE_SVC);
      $display("test gate done");
   endtask : t_gate

   task automatic t_parity();
      tgt.set_phase(3'h1);
      wait_irq(60);
      read_cause(CAUSE_SVC);
      load_count(24'h000002);
      host_cmd(CMD_PAD_XFER);
      tgt.beat(1'b1);
      check("auto atn", atn_out, 1'b1);
      check("irq deferred", irq, 1'b0);
      tgt.beat(1'b0);
      wait_irq(20);
      check("parity flag", bus_phase_status_reg[STAT_PARITY_BIT], 1'b1);
      check("count zero early", bus_phase_status_reg[STAT_CNTZ_BIT], 1'b0);
      read_cause(CAUSE_SVC);
      tgt.beat(1'b0);
      wait_irq(20);
      check("count zero", bus_phase_status_reg[STAT_CNTZ_BIT], 1'b1);
      read_cause(CAUSE_SVC);
      check("atn kept", atn_out, 1'b1);
      tgt.drop_bsy();
      wait_irq(20);
      check("parity on disc", bus_phase_status_reg[STAT_PARITY_BIT], 1'b1);
      read_cause(CAUSE_DISC);
      $display("test parity done");
   endtask : t_parity

   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (40) @(posedge clock);
      t_bad_cmd();
      t_phase_change();
      t_msg_in();
      t_gate();
      t_parity();
      give_verdict();
   end
endmodule : sciil_core_tb
